//--- left_hp_mix_params.svh
// register indices, field positions and reset values for the left headphone mix bank
`ifndef LEFT_HP_MIX_PARAMS_SVH
`define LEFT_HP_MIX_PARAMS_SVH

// page-zero register indices
`define IDX_RSVD_A        8'h2D
`define IDX_LAMP_TO_MAIN  8'h2E
`define IDX_LDAC_TO_MAIN  8'h2F
`define IDX_RSVD_B        8'h30
`define IDX_RAMP_TO_MAIN  8'h31
`define IDX_RDAC_TO_MAIN  8'h32
`define IDX_MAIN_LEVEL    8'h33
`define IDX_RSVD_C        8'h34
`define IDX_LAMP_TO_COM   8'h35
`define IDX_LDAC_TO_COM   8'h36
`define IDX_RSVD_D        8'h37

// route register layout
`define ROUTE_EN_BIT      7
`define ATTEN_MSB         6
`define ATTEN_LSB         0
`define ATTEN_MUTE_MIN    7'h76
`define ROUTE_RESET       8'h00

// level register layout
`define LVL_GAIN_MSB      7
`define LVL_GAIN_LSB      4
`define LVL_UNMUTE_BIT    3
`define LVL_HIZ_BIT       2
`define LVL_PEND_BIT      1
`define LVL_POWER_BIT     0
`define LVL_RESET         8'h06

// reserved slots and counts
`define RSVD_RESET        8'h00
`define NUM_ROUTES        6
`define NUM_MAIN_ROUTES   4
`define NUM_RSVD          4
`define SLOT_NONE         3'h7
`define RSVD_NONE         3'h4
`define READ_UNMAPPED     8'h00
`define ATTEN_RESET       7'h00
`define PEND_RESET        1'h1

`endif

//--- left_hp_mix_pkg.sv
// shared types for the left headphone mix bank
package left_hp_mix_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] atten_t;
    typedef logic [3:0] lvl_gain_t;
    typedef logic [2:0] slot_t;
endpackage

//--- route_if.sv
// carrier between the bank and one source-to-output route path
`timescale 1ns/1ns
interface route_if;
    logic                        wr;
    left_hp_mix_pkg::reg_byte_t  wdata;
    left_hp_mix_pkg::reg_byte_t  value;
    left_hp_mix_pkg::atten_t     applied;
    logic                        muted;
    logic                        pending;

    modport ctrl (output wr, output wdata, input value, input applied, input muted, input pending);
    modport path (input wr, input wdata, output value, output applied, output muted, output pending);
endinterface

//--- route_path.sv
// one route register with its stepped attenuation and mute decode
`timescale 1ns/1ns
`include "left_hp_mix_params.svh"
module route_path (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    reset_n,
    input  wire logic    ce,
    // register and path signals
    route_if.path        bus
);
    left_hp_mix_pkg::reg_byte_t  value_q;
    left_hp_mix_pkg::reg_byte_t  value_d;
    left_hp_mix_pkg::atten_t     applied_q;
    left_hp_mix_pkg::atten_t     applied_d;
    logic                        muted_q;
    logic                        muted_d;
    left_hp_mix_pkg::atten_t     target;

    assign target = value_q[`ATTEN_MSB:`ATTEN_LSB];

    // stored byte holds until the next write; applied gain walks one code per cycle
    // so a big jump never reaches the analog path as a single click
    always_comb begin
        value_d = value_q;
        if (bus.wr) begin
            value_d = bus.wdata;
        end
        applied_d = applied_q;
        if (applied_q < target) begin
            applied_d = applied_q + 7'h01;
        end else if (applied_q > target) begin
            applied_d = applied_q - 7'h01;
        end
        muted_d = (applied_d >= `ATTEN_MUTE_MIN);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            value_q   <= `ROUTE_RESET;
            applied_q <= `ATTEN_RESET;
            muted_q   <= 1'b0;
        end else if (ce) begin
            value_q   <= value_d;
            applied_q <= applied_d;
            muted_q   <= muted_d;
        end
    end

    assign bus.value   = value_q;
    assign bus.applied = applied_q;
    assign bus.muted   = muted_q;
    assign bus.pending = (applied_q != target);
endmodule // route_path

//--- left_hp_mix_route_regs.sv
// left headphone mix route and level register bank
`timescale 1ns/1ns
`include "left_hp_mix_params.svh"
module left_hp_mix_route_regs (
    // clock, enable and reset
    input  wire logic          CLK,
    input  wire logic          RESET_N,
    input  wire logic          CE,
    // register access port
    input  wire logic          REG_WR,
    input  wire logic          REG_RD,
    input  wire logic [7:0]    REG_INDEX,
    input  wire logic [7:0]    REG_WDATA,
    output logic      [7:0]    REG_RDATA,
    // route controls toward the analog mixer
    output logic      [5:0]    ROUTE_EN,
    output logic      [41:0]   ROUTE_ATTEN,
    output logic      [5:0]    ROUTE_MUTE,
    // main output driver controls
    output logic      [3:0]    MAIN_LEVEL_GAIN,
    output logic               MAIN_UNMUTE,
    output logic               MAIN_HIZ_PD,
    output logic               MAIN_POWER_UP,
    output logic               MAIN_GAIN_PENDING
);
    // route slots, in the order of the ROUTE_EN, ROUTE_MUTE and ROUTE_ATTEN buses:
    //   slot 0: left input amp to main out
    //   slot 1: left dac path one to main out
    //   slot 2: right input amp to main out
    //   slot 3: right dac path one to main out
    //   slot 4: left input amp to common out
    //   slot 5: left dac path one to common out
    // only slots 0 to 3 feed the pending status of the main output
    // index to route slot; the slot order also sets the output bus order
    function automatic left_hp_mix_pkg::slot_t route_slot(input logic [7:0] idx);
        unique case (idx)
            `IDX_LAMP_TO_MAIN: route_slot = 3'h0;
            `IDX_LDAC_TO_MAIN: route_slot = 3'h1;
            `IDX_RAMP_TO_MAIN: route_slot = 3'h2;
            `IDX_RDAC_TO_MAIN: route_slot = 3'h3;
            `IDX_LAMP_TO_COM:  route_slot = 3'h4;
            `IDX_LDAC_TO_COM:  route_slot = 3'h5;
            default:           route_slot = `SLOT_NONE;
        endcase
    endfunction

    // reserved slots fill the gaps of the map: 0 below the first route, 1 between
    // the left dac and right amp routes, 2 after the level register and 3 after
    // the common-out routes; each keeps a full byte
    // index to reserved slot
    function automatic left_hp_mix_pkg::slot_t rsvd_slot(input logic [7:0] idx);
        unique case (idx)
            `IDX_RSVD_A: rsvd_slot = 3'h0;
            `IDX_RSVD_B: rsvd_slot = 3'h1;
            `IDX_RSVD_C: rsvd_slot = 3'h2;
            `IDX_RSVD_D: rsvd_slot = 3'h3;
            default:     rsvd_slot = `RSVD_NONE;
        endcase
    endfunction

    // the level register is decoded for both write and read
    function automatic logic is_level(input logic [7:0] idx);
        is_level = (idx == `IDX_MAIN_LEVEL);
    endfunction

    // level, reserved and read-back state
    left_hp_mix_pkg::reg_byte_t  level_q;
    left_hp_mix_pkg::reg_byte_t  level_d;
    left_hp_mix_pkg::reg_byte_t  rsvd_q [`NUM_RSVD];
    left_hp_mix_pkg::reg_byte_t  rsvd_d [`NUM_RSVD];
    left_hp_mix_pkg::reg_byte_t  rdata_q;
    left_hp_mix_pkg::reg_byte_t  rdata_d;

    // pending summary and write decode
    logic                        pend_q;
    logic                        pend_d;
    logic [`NUM_ROUTES-1:0]      route_pend;
    left_hp_mix_pkg::slot_t      wr_slot;
    left_hp_mix_pkg::slot_t      wr_rsvd;
    logic                        level_wr;

    // one carrier per route path
    route_if rif[`NUM_ROUTES] ();

    // index decode shared by the write and read sides
    assign wr_slot  = route_slot(REG_INDEX);
    assign wr_rsvd  = rsvd_slot(REG_INDEX);
    assign level_wr = REG_WR && is_level(REG_INDEX);

    // one path per route register; each takes only its own index
    // and drives its own slice of the route buses
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_ROUTES; gi = gi + 1) begin : g_route
            assign rif[gi].wr    = REG_WR && (wr_slot == 3'(gi));
            assign rif[gi].wdata = REG_WDATA;
            assign ROUTE_EN[gi]  = rif[gi].value[`ROUTE_EN_BIT];
            assign ROUTE_ATTEN[gi*7 +: 7] = rif[gi].applied;
            assign ROUTE_MUTE[gi] = rif[gi].muted;
            assign route_pend[gi] = rif[gi].pending;
            route_path u_path (
                .clk     (CLK),
                .reset_n (RESET_N),
                .ce      (CE),
                .bus     (rif[gi])
            );
        end
    endgenerate

    // flattened route values so the read mux can index them by slot
    left_hp_mix_pkg::reg_byte_t  route_val [`NUM_ROUTES];
    generate
        for (gi = 0; gi < `NUM_ROUTES; gi = gi + 1) begin : g_val
            assign route_val[gi] = rif[gi].value;
        end
    endgenerate

    function automatic left_hp_mix_pkg::reg_byte_t rif_value(input left_hp_mix_pkg::slot_t s);
        rif_value = route_val[s];
    endfunction

    // level register; the status bit is never taken from software, it follows the pending summary.
    // level codes above nine are not filtered, the host is trusted to avoid them
    always_comb begin
        level_d = level_q;
        if (level_wr) begin
            level_d[`LVL_GAIN_MSB:`LVL_GAIN_LSB] = REG_WDATA[`LVL_GAIN_MSB:`LVL_GAIN_LSB];
            level_d[`LVL_UNMUTE_BIT] = REG_WDATA[`LVL_UNMUTE_BIT];
            level_d[`LVL_HIZ_BIT]    = REG_WDATA[`LVL_HIZ_BIT];
            level_d[`LVL_POWER_BIT]  = REG_WDATA[`LVL_POWER_BIT];
        end
        level_d[`LVL_PEND_BIT] = pend_d;
    end

    // level state freezes while the clock enable is low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            level_q <= `LVL_RESET;
        end else if (CE) begin
            level_q <= level_d;
        end
    end

    // reserved slots keep a stray write so it reads back, though the host must not write them
    always_comb begin
        for (int i = 0; i < `NUM_RSVD; i++) begin
            rsvd_d[i] = rsvd_q[i];
        end
        if (REG_WR && wr_rsvd != `RSVD_NONE) begin
            rsvd_d[wr_rsvd[1:0]] = REG_WDATA;
        end
    end

    // reserved storage freezes with the rest of the bank
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < `NUM_RSVD; i++) begin
                rsvd_q[i] <= `RSVD_RESET;
            end
        end else if (CE) begin
            for (int i = 0; i < `NUM_RSVD; i++) begin
                rsvd_q[i] <= rsvd_d[i];
            end
        end
    end

    // pending while any main-out route is still stepping toward its target;
    // common-out routes are left out, they do not feed the main output
    assign pend_d = |route_pend[`NUM_MAIN_ROUTES-1:0];

    // registered summary so the status output comes straight from a flop
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pend_q <= `PEND_RESET;
        end else if (CE) begin
            pend_q <= pend_d;
        end
    end

    // read mux; answer lands one cycle after the strobe and holds until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD) begin
            rdata_d = `READ_UNMAPPED;
            if (wr_slot != `SLOT_NONE) begin
                rdata_d = rif_value(wr_slot);
            end else if (wr_rsvd != `RSVD_NONE) begin
                rdata_d = rsvd_q[wr_rsvd[1:0]];
            end else if (is_level(REG_INDEX)) begin
                rdata_d = level_q;
            end
        end
    end

    // read data also freezes while the clock enable is low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= `READ_UNMAPPED;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    // every output is a flop of this module or of a route path
    assign REG_RDATA         = rdata_q;
    assign MAIN_LEVEL_GAIN   = level_q[`LVL_GAIN_MSB:`LVL_GAIN_LSB];
    assign MAIN_UNMUTE       = level_q[`LVL_UNMUTE_BIT];
    assign MAIN_HIZ_PD       = level_q[`LVL_HIZ_BIT];
    assign MAIN_POWER_UP     = level_q[`LVL_POWER_BIT];
    assign MAIN_GAIN_PENDING = pend_q;
endmodule // left_hp_mix_route_regs

//--- left_hp_mix_checker.sv
// port checker for the left headphone mix register bank
`timescale 1ns/1ns
module left_hp_mix_checker (
    // clock and access port
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic        CE,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_INDEX,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    // controls out of the bank
    input wire logic [5:0]  ROUTE_EN,
    input wire logic [41:0] ROUTE_ATTEN,
    input wire logic [5:0]  ROUTE_MUTE,
    input wire logic [3:0]  MAIN_LEVEL_GAIN,
    input wire logic        MAIN_UNMUTE,
    input wire logic        MAIN_HIZ_PD,
    input wire logic        MAIN_POWER_UP,
    input wire logic        MAIN_GAIN_PENDING
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // writes only count on an enabled edge
    logic wr;
    logic lw;
    assign wr = CE && REG_WR;
    assign lw = wr && REG_INDEX == 8'h33;
    a_main_route_en: assert property (wr && REG_INDEX == 8'h32 |=> ROUTE_EN[3] == $past(REG_WDATA[7]))
        else $error("main route enable wrong");
    a_com_route_en: assert property (wr && REG_INDEX == 8'h35 |=> ROUTE_EN[4] == $past(REG_WDATA[7]))
        else $error("common route enable wrong");
    a_level_gain_set: assert property (lw |=> MAIN_LEVEL_GAIN == $past(REG_WDATA[7:4]))
        else $error("level gain wrong");
    a_unmute_bit_set: assert property (lw |=> MAIN_UNMUTE == $past(REG_WDATA[3]))
        else $error("unmute wrong");
    a_hiz_bit_set: assert property (lw |=> MAIN_HIZ_PD == $past(REG_WDATA[2]))
        else $error("powered-down drive wrong");
    a_power_bit_set: assert property (lw |=> MAIN_POWER_UP == $past(REG_WDATA[0]))
        else $error("power up wrong");
    a_atten_one_step: assert property ($changed(ROUTE_ATTEN[6:0]) |->
        (ROUTE_ATTEN[6:0] - $past(ROUTE_ATTEN[6:0])) inside {7'h01, 7'h7F})
        else $error("attenuation jumped");
    a_mute_code_map: assert property ($stable(ROUTE_ATTEN[6:0]) |-> ROUTE_MUTE[0] == (ROUTE_ATTEN[6:0] >= 7'h76))
        else $error("mute decode wrong");
    a_unmapped_zero: assert property (CE && REG_RD && !(REG_INDEX inside {[8'h2D:8'h37]}) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_pend_read_back: assert property (CE && REG_RD && REG_INDEX == 8'h33 |=> REG_RDATA[1] == $past(MAIN_GAIN_PENDING))
        else $error("status bit read differs from pending output");
    a_freeze_hold: assert property (!CE |=> $stable(ROUTE_EN) && $stable(MAIN_LEVEL_GAIN) && $stable(REG_RDATA))
        else $error("state moved with enable low");
    // main scenarios reached
    c_level_write: cover property (lw);
    c_path_muted: cover property (ROUTE_MUTE[0]);
    c_unmapped_read: cover property (CE && REG_RD && REG_INDEX == 8'h38);
    c_frozen_write: cover property (!CE && REG_WR);
endmodule // left_hp_mix_checker

bind left_hp_mix_route_regs left_hp_mix_checker chk (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_INDEX(REG_INDEX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ROUTE_EN(ROUTE_EN),
    .ROUTE_ATTEN(ROUTE_ATTEN), .ROUTE_MUTE(ROUTE_MUTE), .MAIN_LEVEL_GAIN(MAIN_LEVEL_GAIN),
    .MAIN_UNMUTE(MAIN_UNMUTE), .MAIN_HIZ_PD(MAIN_HIZ_PD), .MAIN_POWER_UP(MAIN_POWER_UP),
    .MAIN_GAIN_PENDING(MAIN_GAIN_PENDING));

//--- left_hp_mix_route_regs_bench.sv
// self-checking bench for the left headphone mix bank
`timescale 1ns/1ns
module left_hp_mix_route_regs_bench;
    logic        CLK;
    logic        RESET_N;
    logic        CE;
    logic        REG_WR;
    logic        REG_RD;
    logic [7:0]  REG_INDEX;
    logic [7:0]  REG_WDATA;
    logic [7:0]  REG_RDATA;
    logic [5:0]  ROUTE_EN;
    logic [41:0] ROUTE_ATTEN;
    logic [5:0]  ROUTE_MUTE;
    logic [3:0]  MAIN_LEVEL_GAIN;
    logic        MAIN_UNMUTE;
    logic        MAIN_HIZ_PD;
    logic        MAIN_POWER_UP;
    logic        MAIN_GAIN_PENDING;
    int          error_cnt;
    int          n_tests;
    int          cycles;
    logic [7:0]  idx [6];

    left_hp_mix_route_regs dut (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_INDEX(REG_INDEX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .ROUTE_EN(ROUTE_EN),
        .ROUTE_ATTEN(ROUTE_ATTEN), .ROUTE_MUTE(ROUTE_MUTE), .MAIN_LEVEL_GAIN(MAIN_LEVEL_GAIN),
        .MAIN_UNMUTE(MAIN_UNMUTE), .MAIN_HIZ_PD(MAIN_HIZ_PD), .MAIN_POWER_UP(MAIN_POWER_UP),
        .MAIN_GAIN_PENDING(MAIN_GAIN_PENDING));

    // 25 MHz clock
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // the tests need under a thousand cycles, so this only trips on a hang
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobes drop on the same edge that takes them, leaving an idle cycle between calls
    task automatic wr(logic [7:0] i, logic [7:0] d);
        @(posedge CLK);
        REG_WR    <= 1'b1;
        REG_INDEX <= i;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(logic [7:0] i, logic [7:0] exp);
        @(posedge CLK);
        REG_RD    <= 1'b1;
        REG_INDEX <= i;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(negedge CLK);
        chk("read data", exp, REG_RDATA);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        idx = '{8'h2E, 8'h2F, 8'h31, 8'h32, 8'h35, 8'h36};
        RESET_N = 1'b0;
        CE = 1'b1;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_INDEX = 8'h00;
        REG_WDATA = 8'h00;
        repeat (6) @(posedge CLK);
        chk("pending in reset", 8'h01, MAIN_GAIN_PENDING);
        RESET_N <= 1'b1;
        for (int i = 8'h2D; i <= 8'h37; i++) begin
            rd(8'(i), (i == 8'h33) ? 8'h04 : 8'h00);
        end
        chk("hiz after reset", 8'h01, MAIN_HIZ_PD);
        $display("reset values done");
        for (int i = 0; i < 6; i++) begin
            wr(idx[i], 8'h80 | 8'(i + 1));
        end
        repeat (20) @(posedge CLK);
        for (int i = 0; i < 6; i++) begin
            chk("route enable", 8'h01, ROUTE_EN[i]);
            chk("route atten", 8'(i + 1), ROUTE_ATTEN[i*7+:7]);
            rd(idx[i], 8'h80 | 8'(i + 1));
        end
        $display("route slots done");
        wr(8'h2E, 8'h76);
        repeat (2) @(posedge CLK);
        chk("pending set", 8'h01, MAIN_GAIN_PENDING);
        repeat (130) @(posedge CLK);
        chk("muted at 118", 8'h01, ROUTE_MUTE[0]);
        chk("route cleared", 8'h00, ROUTE_EN[0]);
        rd(8'h33, 8'h04);
        wr(8'h2E, 8'h75);
        repeat (5) @(posedge CLK);
        chk("live at 117", 8'h00, ROUTE_MUTE[0]);
        $display("mute boundary done");
        for (int g = 0; g < 10; g++) begin
            wr(8'h33, {4'(g), g[0], !g[0], 1'b1, g[1]});
            rd(8'h33, {4'(g), g[0], !g[0], 1'b0, g[1]});
            chk("level gain", 8'(g), MAIN_LEVEL_GAIN);
            chk("unmute", 8'(g[0]), MAIN_UNMUTE);
            chk("hiz", 8'(!g[0]), MAIN_HIZ_PD);
            chk("power", 8'(g[1]), MAIN_POWER_UP);
        end
        $display("level codes done");
        wr(8'h38, 8'hFF);
        rd(8'h38, 8'h00);
        rd(8'h2C, 8'h00);
        rd(8'h37, 8'h00);
        $display("unmapped done");
        // a write while the clock enable is low must not land
        @(posedge CLK);
        CE <= 1'b0;
        wr(8'h2F, 8'h7F);
        CE <= 1'b1;
        rd(8'h2F, 8'h82);
        chk("frozen enable", 8'h01, ROUTE_EN[1]);
        $display("clock enable done");
        // a reset in mid run brings every register back to its reset value
        @(posedge CLK);
        RESET_N <= 1'b0;
        @(negedge CLK);
        chk("pending in reset", 8'h01, MAIN_GAIN_PENDING);
        chk("route after reset", 8'h00, ROUTE_EN);
        chk("atten after reset", 8'h00, ROUTE_ATTEN[6:0]);
        @(posedge CLK);
        RESET_N <= 1'b1;
        rd(8'h2F, 8'h00);
        rd(8'h33, 8'h04);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule // left_hp_mix_route_regs_bench
